// ### shared/sat_pkg.sv
// Types shared by the segment translation unit and its bench.
`default_nettype none
package sat_pkg;

  typedef enum logic [1:0] {
    SAT_FLT_NONE = 2'b00,
    SAT_FLT_GP = 2'b01,
    SAT_FLT_NP = 2'b10
  } sat_fault_t;

  typedef enum logic [1:0] {
    SAT_ST_IDLE = 2'b00,
    SAT_ST_FETCH = 2'b01,
    SAT_ST_DONE = 2'b10
  } sat_state_t;

  typedef struct packed {
    logic [15:0] sel;
    logic [31:0] base;
    logic [19:0] limit;
    logic gran;
    logic [7:0] acc;
    logic isNull;
  } sat_seg_t;

  typedef struct packed {
    logic valid;
    logic load;
    logic [2:0] seg;
    logic [15:0] selector;
    logic [31:0] offset;
    logic write;
    logic fetch;
  } sat_core_req_t;

  typedef struct packed {
    logic done;
    logic fault;
    sat_fault_t faultType;
    logic [1:0] requester_privilege;
    logic [1:0] descriptor_privilege;
    logic pageReq;
    logic [31:0] linAddr;
    logic physValid;
    logic physWide;
    logic [35:0] physAddr;
  } sat_core_rsp_t;

  typedef struct packed {
    logic rd;
    logic [31:0] addr;
  } sat_desc_rd_t;

endpackage
`default_nettype wire

// ### shared/sat_regs.svh
// Register offsets, field positions and reset values.
`ifndef SAT_REGS_SVH
`define SAT_REGS_SVH

// Word indices on the register bus; byte address is four times the index.
`define SAT_REG_GTB 3'h0
`define SAT_REG_LTB 3'h1
`define SAT_REG_CTRL 3'h2
`define SAT_REG_STAT 3'h3

// Control register fields.
`define SAT_CTRL_PAGE 0
`define SAT_CTRL_EXT 5
`define SAT_CTRL_MASK 32'h00000021

// Status register fields.
`define SAT_STAT_BUSY 0
`define SAT_STAT_FLT_LO 1
`define SAT_STAT_FLT_HI 2
`define SAT_STAT_CNT_LO 8
`define SAT_STAT_CNT_HI 15

// Selector fields.
`define SAT_SEL_RPL_LO 0
`define SAT_SEL_RPL_HI 1
`define SAT_SEL_TBL 2
`define SAT_SEL_IDX_LO 3
`define SAT_SEL_IDX_HI 15

// Descriptor fields in the 64-bit table entry.
`define SAT_D_LIM0_LO 0
`define SAT_D_LIM0_HI 15
`define SAT_D_BASE0_LO 16
`define SAT_D_BASE0_HI 39
`define SAT_D_ACC_LO 40
`define SAT_D_ACC_HI 47
`define SAT_D_LIM1_LO 48
`define SAT_D_LIM1_HI 51
`define SAT_D_GRAN 55
`define SAT_D_BASE1_LO 56
`define SAT_D_BASE1_HI 63

// Access byte fields once cached.
`define SAT_ACC_P 7
`define SAT_ACC_S 4
`define SAT_ACC_EXEC 3
`define SAT_ACC_RW 1

// Segment register numbers.
`define SAT_SEG_CODE 3'h1
`define SAT_SEG_STACK 3'h2
`define SAT_SEG_DATA 3'h3

// Reset contents of the cached segment parts.
`define SAT_RST_CODE_BASE 32'hffff0000
`define SAT_RST_DATA_BASE 32'h00000000
`define SAT_RST_LIMIT 20'h0ffff
`define SAT_RST_CODE_ACC 8'h9a
`define SAT_RST_DATA_ACC 8'h92

// Descriptor size as a shift of the index (8 bytes).
`define SAT_DESC_SHIFT 3
`define SAT_GRAN_FILL 12'hfff

`endif

// ### src/sat_addr_xlate.sv
// Segment selector decode, descriptor caching and linear address unit.
//
// Notes on behaviour
// - Requests carry 16-bit selector and 32-bit offset.
// - Selector bits 3..15 index 8192 descriptors.
// - Entry address is table base plus index times 8.
// - Selector bit 2 picks global or local table.
// - Selector bits 0..1 give requester privilege.
// - Null selector loads into data registers freely.
// - Access through null register raises a fault.
// - Null into code or stack register faults.
// - Rights and limit checked before forming address.
// - Linear address is base plus offset.
// - Offset beyond limit raises protection fault.
// - Base 0, 4 GB limit never limit-faults.
// - No paging: linear goes out as physical.
// - Default physical space is flat 32-bit.
// - Extension flag bit 5 sets physWide; upper 4 address bits stay zero.
// - Reset: data base 0, code near top.
// - Writes to read-only code segments fault.
// - Granularity flag scales limit to 4 KB units.
// - Absent descriptor load raises not-present fault.
// - Loads cache base, limit and access rights.
//
// Added by the designer: the address map and register access over Avalon-MM.
`default_nettype none
`include "sat_regs.svh"
module sat_addr_xlate
  import sat_pkg::*;
#(
  parameter int SegCount = 6,
  parameter int CntW = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output var logic [31:0] avs_readdata,
  output var logic avs_waitrequest,
  input wire sat_core_req_t coreReq,
  output var sat_core_rsp_t coreRsp,
  output var sat_desc_rd_t descRd,
  input wire logic descValid,
  input wire logic [63:0] descData
);

  // ==========================================================================
  // State
  // ==========================================================================
  logic [31:0] gtb_ff, nxt_gtb;
  logic [31:0] ltb_ff, nxt_ltb;
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [31:0] rdata_ff, nxt_rdata;
  logic wait_ff, nxt_wait;

  sat_state_t state_ff, nxt_state;
  sat_seg_t seg_ff [SegCount];
  sat_seg_t nxt_seg [SegCount];
  sat_core_rsp_t rsp_ff, nxt_rsp;
  sat_desc_rd_t desc_ff, nxt_desc;
  sat_fault_t lastFlt_ff, nxt_lastFlt;
  logic [CntW-1:0] fltCnt_ff, nxt_fltCnt;

  logic segOk;
  logic [2:0] segIdx;
  sat_seg_t curSeg;
  logic inRange;
  logic selNull;
  logic [12:0] selIdx;
  logic [31:0] tblBase;
  logic [31:0] linear;
  logic accBlocked;
  logic busReq;

  // ==========================================================================
  // Register bus slave
  // ==========================================================================
  function automatic logic [31:0] applyBe(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  assign busReq = avs_read | avs_write;

  always_comb begin
    nxt_gtb = gtb_ff;
    nxt_ltb = ltb_ff;
    nxt_ctrl = ctrl_ff;
    nxt_rdata = rdata_ff;
    // One wait cycle per request, then a single accepting cycle.
    nxt_wait = !(busReq && wait_ff);
    if (busReq && wait_ff) begin
      case (avs_address)
        `SAT_REG_GTB: begin
          nxt_rdata = gtb_ff;
        end
        `SAT_REG_LTB: begin
          nxt_rdata = ltb_ff;
        end
        `SAT_REG_CTRL: begin
          nxt_rdata = ctrl_ff;
        end
        `SAT_REG_STAT: begin
          nxt_rdata = '0;
          nxt_rdata[`SAT_STAT_BUSY] = (state_ff != SAT_ST_IDLE);
          nxt_rdata[`SAT_STAT_FLT_HI:`SAT_STAT_FLT_LO] = lastFlt_ff;
          nxt_rdata[`SAT_STAT_CNT_HI:`SAT_STAT_CNT_LO] = fltCnt_ff;
        end
        default: begin
          nxt_rdata = '0;
        end
      endcase
    end
    if (avs_write && !wait_ff) begin
      case (avs_address)
        `SAT_REG_GTB: begin
          nxt_gtb = applyBe(gtb_ff, avs_writedata, avs_byteenable);
        end
        `SAT_REG_LTB: begin
          nxt_ltb = applyBe(ltb_ff, avs_writedata, avs_byteenable);
        end
        `SAT_REG_CTRL: begin
          nxt_ctrl = applyBe(ctrl_ff, avs_writedata, avs_byteenable) &
                     `SAT_CTRL_MASK;
        end
        default: begin
          nxt_ctrl = ctrl_ff;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gtb_ff <= '0;
      ltb_ff <= '0;
      ctrl_ff <= '0;
      rdata_ff <= '0;
      wait_ff <= 1'b1;
    end else begin
      gtb_ff <= nxt_gtb;
      ltb_ff <= nxt_ltb;
      ctrl_ff <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
      wait_ff <= nxt_wait;
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;

  // ==========================================================================
  // Selector decode and access checks
  // ==========================================================================
  always_comb begin
    segOk = (coreReq.seg < 3'(SegCount));
    segIdx = segOk ? coreReq.seg : 3'h0;
    curSeg = seg_ff[segIdx];
    selIdx = coreReq.selector[`SAT_SEL_IDX_HI:`SAT_SEL_IDX_LO];
    selNull = (selIdx == 13'h0000) &&
              !coreReq.selector[`SAT_SEL_TBL];
    tblBase = coreReq.selector[`SAT_SEL_TBL] ? ltb_ff : gtb_ff;
    linear = curSeg.base + coreReq.offset;
    // Code is never writable; data needs the writable bit for stores,
    // code needs the readable bit for data reads, fetches need code.
    if (coreReq.fetch) begin
      accBlocked = !curSeg.acc[`SAT_ACC_EXEC];
    end else if (coreReq.write) begin
      accBlocked = curSeg.acc[`SAT_ACC_EXEC] ||
                   !curSeg.acc[`SAT_ACC_RW];
    end else begin
      accBlocked = curSeg.acc[`SAT_ACC_EXEC] &&
                   !curSeg.acc[`SAT_ACC_RW];
    end
  end

  sat_limit_check #(
    .LimW(20)
  ) u_limit (
    .limit(curSeg.limit),
    .gran(curSeg.gran),
    .offset(coreReq.offset),
    .inRange(inRange)
  );

  // ==========================================================================
  // Translation sequencer and segment cache
  // ==========================================================================
  always_comb begin
    nxt_state = state_ff;
    nxt_seg = seg_ff;
    nxt_rsp = rsp_ff;
    nxt_rsp.done = 1'b0;
    nxt_desc = desc_ff;
    nxt_lastFlt = lastFlt_ff;
    nxt_fltCnt = fltCnt_ff;
    case (state_ff)
      SAT_ST_IDLE: begin
        // The request stays stable until done, so it is read directly.
        if (coreReq.valid) begin
          nxt_rsp = '0;
          nxt_rsp.done = 1'b1;
          nxt_rsp.requester_privilege = coreReq.selector[`SAT_SEL_RPL_HI:`SAT_SEL_RPL_LO];
          nxt_rsp.descriptor_privilege = curSeg.acc[6:5];
          nxt_state = SAT_ST_DONE;
          if (!segOk) begin
            nxt_rsp.fault = 1'b1;
            nxt_rsp.faultType = SAT_FLT_GP;
          end else if (coreReq.load) begin
            nxt_rsp.requester_privilege = coreReq.selector[`SAT_SEL_RPL_HI:
                                           `SAT_SEL_RPL_LO];
            if (selNull) begin
              if (coreReq.seg == `SAT_SEG_CODE ||
                  coreReq.seg == `SAT_SEG_STACK) begin
                nxt_rsp.fault = 1'b1;
                nxt_rsp.faultType = SAT_FLT_GP;
              end else begin
                nxt_seg[segIdx].sel = coreReq.selector;
                nxt_seg[segIdx].isNull = 1'b1;
              end
            end else begin
              nxt_desc.rd = 1'b1;
              nxt_desc.addr = tblBase +
                {16'h0000, selIdx, 3'h0};
              nxt_rsp.done = 1'b0;
              nxt_state = SAT_ST_FETCH;
            end
          end else if (curSeg.isNull) begin
            nxt_rsp.fault = 1'b1;
            nxt_rsp.faultType = SAT_FLT_GP;
          end else if (!inRange || accBlocked) begin
            nxt_rsp.fault = 1'b1;
            nxt_rsp.faultType = SAT_FLT_GP;
          end else begin
            nxt_rsp.linAddr = linear;
            nxt_rsp.physWide = ctrl_ff[`SAT_CTRL_EXT];
            if (ctrl_ff[`SAT_CTRL_PAGE]) begin
              nxt_rsp.pageReq = 1'b1;
            end else begin
              nxt_rsp.physValid = 1'b1;
              nxt_rsp.physAddr = {4'h0, linear};
            end
          end
        end
      end
      SAT_ST_FETCH: begin
        if (descValid) begin
          nxt_desc = '0;
          nxt_rsp.done = 1'b1;
          nxt_rsp.descriptor_privilege = descData[46:45];
          nxt_state = SAT_ST_DONE;
          if (!descData[`SAT_D_ACC_LO + `SAT_ACC_P]) begin
            nxt_rsp.fault = 1'b1;
            nxt_rsp.faultType = SAT_FLT_NP;
          end else if (!descData[`SAT_D_ACC_LO + `SAT_ACC_S]) begin
            nxt_rsp.fault = 1'b1;
            nxt_rsp.faultType = SAT_FLT_GP;
          end else begin
            nxt_seg[segIdx].sel = coreReq.selector;
            nxt_seg[segIdx].isNull = 1'b0;
            nxt_seg[segIdx].base = {
              descData[`SAT_D_BASE1_HI:`SAT_D_BASE1_LO],
              descData[`SAT_D_BASE0_HI:`SAT_D_BASE0_LO]};
            nxt_seg[segIdx].limit = {
              descData[`SAT_D_LIM1_HI:`SAT_D_LIM1_LO],
              descData[`SAT_D_LIM0_HI:`SAT_D_LIM0_LO]};
            nxt_seg[segIdx].gran = descData[`SAT_D_GRAN];
            nxt_seg[segIdx].acc =
              descData[`SAT_D_ACC_HI:`SAT_D_ACC_LO];
          end
        end
      end
      SAT_ST_DONE: begin
        nxt_state = SAT_ST_IDLE;
      end
      default: begin
        nxt_state = SAT_ST_IDLE;
      end
    endcase
    // A fault clears any address so nothing downstream uses it.
    if (nxt_rsp.done && nxt_rsp.fault) begin
      nxt_rsp.linAddr = '0;
      nxt_rsp.physAddr = '0;
      nxt_rsp.pageReq = 1'b0;
      nxt_rsp.physValid = 1'b0;
      nxt_lastFlt = nxt_rsp.faultType;
      if (fltCnt_ff != {CntW{1'b1}}) begin
        nxt_fltCnt = fltCnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= SAT_ST_IDLE;
      rsp_ff <= '0;
      desc_ff <= '0;
      lastFlt_ff <= SAT_FLT_NONE;
      fltCnt_ff <= '0;
      for (int i = 0; i < SegCount; i++) begin
        seg_ff[i].sel <= '0;
        seg_ff[i].base <= `SAT_RST_DATA_BASE;
        seg_ff[i].limit <= `SAT_RST_LIMIT;
        seg_ff[i].gran <= 1'b0;
        seg_ff[i].acc <= `SAT_RST_DATA_ACC;
        seg_ff[i].isNull <= 1'b0;
      end
      seg_ff[`SAT_SEG_CODE].base <= `SAT_RST_CODE_BASE;
      seg_ff[`SAT_SEG_CODE].acc <= `SAT_RST_CODE_ACC;
    end else begin
      state_ff <= nxt_state;
      rsp_ff <= nxt_rsp;
      desc_ff <= nxt_desc;
      lastFlt_ff <= nxt_lastFlt;
      fltCnt_ff <= nxt_fltCnt;
      for (int i = 0; i < SegCount; i++) begin
        seg_ff[i] <= nxt_seg[i];
      end
    end
  end

  assign coreRsp = rsp_ff;
  assign descRd = desc_ff;

endmodule
`default_nettype wire

// ### src/sat_limit_check.sv
// Segment limit scaling and offset range check.
`default_nettype none
`include "sat_regs.svh"
module sat_limit_check #(
  parameter int LimW = 20
) (
  input wire logic [LimW-1:0] limit,
  input wire logic gran,
  input wire logic [31:0] offset,
  output logic inRange
);
  logic [31:0] effLimit;

  always_comb begin
    if (gran) begin
      effLimit = {limit, `SAT_GRAN_FILL};
    end else begin
      effLimit = {{(32-LimW){1'b0}}, limit};
    end
    inRange = (offset <= effLimit);
  end
endmodule
`default_nettype wire

// ### verif/sat_desc_mem.sv
// Descriptor table memory that answers descriptor reads after a lag.
`default_nettype none
module sat_desc_mem
  import sat_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire sat_desc_rd_t descRd,
  input wire logic [1:0] lag,
  output logic descValid,
  output logic [63:0] descData
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [63:0] mem [256];
  int waitCnt;
  logic answered;
  initial begin
    descValid = 1'b0;
    descData = 64'h0;
    foreach (mem[i]) mem[i] = 64'h0;
  end
  // Data is scrambled once its one-cycle strobe has passed.
  always @(posedge clk) begin
    descValid <= 1'b0;
    if (descValid) descData <= ~descData;
    if (rst || !descRd.rd) begin
      waitCnt = 0;
      answered = 1'b0;
    end else if (!answered && waitCnt >= lag) begin
      descValid <= 1'b1;
      descData <= mem[descRd.addr[10:3]];
      answered = 1'b1;
    end else begin
      waitCnt++;
    end
  end
endmodule
`default_nettype wire

// ### verif/sat_monitor.sv
// Concurrent checks on the segment translation unit's ports.
`default_nettype none
module sat_monitor
  import sat_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire sat_core_req_t coreReq,
  input wire sat_core_rsp_t coreRsp,
  input wire sat_desc_rd_t descRd,
  input wire logic descValid,
  input wire logic [63:0] descData
);
  // ==========
  // Shadow of the two table base registers.
  logic [31:0] gtb_ff;
  logic [31:0] ltb_ff;
  wire logic nullSel = coreReq.selector[15:2] == 14'h0;
  wire logic rspLoad = coreRsp.done && coreReq.load;
  always_ff @(posedge clk) begin
    if (rst) begin
      gtb_ff <= 32'h0;
      ltb_ff <= 32'h0;
    end else if (avs_write && !avs_waitrequest) begin
      for (int i = 0; i < 4; i++) begin
        if (avs_byteenable[i] && avs_address == 3'h0) begin
          gtb_ff[8*i+:8] <= avs_writedata[8*i+:8];
        end
        if (avs_byteenable[i] && avs_address == 3'h1) begin
          ltb_ff[8*i+:8] <= avs_writedata[8*i+:8];
        end
      end
    end
  end
  // ==========
  // Properties.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_descAddr;
    $rose(descRd.rd) |-> descRd.addr == (coreReq.selector[2] ? ltb_ff :
      gtb_ff) + {16'h0, coreReq.selector[15:3], 3'h0};
  endproperty
  a_descAddr: assert property (p_descAddr)
    else $error("descriptor address wrong");
  property p_descDone;
    descRd.rd && descValid |=> coreRsp.done;
  endproperty
  a_descDone: assert property (p_descDone)
    else $error("load not finished after descriptor");
  property p_absent;
    descRd.rd && descValid && !descData[47] |=>
      coreRsp.fault && coreRsp.faultType == SAT_FLT_NP;
  endproperty
  a_absent: assert property (p_absent)
    else $error("absent descriptor not refused");
  property p_nullCode;
    rspLoad && nullSel && coreReq.seg inside {3'h1, 3'h2} |->
      coreRsp.fault && coreRsp.faultType == SAT_FLT_GP;
  endproperty
  a_nullCode: assert property (p_nullCode)
    else $error("null code or stack load not refused");
  property p_nullData;
    rspLoad && nullSel && coreReq.seg == 3'h3 |-> !coreRsp.fault;
  endproperty
  a_nullData: assert property (p_nullData)
    else $error("null data load refused");
  property p_suppress;
    coreRsp.done && coreRsp.fault |-> !coreRsp.physValid &&
      !coreRsp.pageReq && coreRsp.faultType != SAT_FLT_NONE;
  endproperty
  a_suppress: assert property (p_suppress)
    else $error("address given with fault");
  property p_rpl;
    rspLoad |-> coreRsp.requester_privilege == coreReq.selector[1:0];
  endproperty
  a_rpl: assert property (p_rpl)
    else $error("privilege field wrong");
  property p_route;
    coreRsp.done && !coreRsp.fault && !coreReq.load |->
      (coreRsp.physValid ^ coreRsp.pageReq) &&
      (!coreRsp.physValid || coreRsp.physAddr[35:32] == 4'h0);
  endproperty
  a_route: assert property (p_route)
    else $error("address routed wrong");
  property p_accTime;
    $rose(coreReq.valid) && !coreReq.load |=> coreRsp.done;
  endproperty
  a_accTime: assert property (p_accTime)
    else $error("access answer late");
  c_load: cover property (rspLoad && !coreRsp.fault);
  c_absent: cover property (coreRsp.faultType == SAT_FLT_NP);
  c_page: cover property (coreRsp.done && coreRsp.pageReq);
endmodule
bind sat_addr_xlate sat_monitor u_mon (.clk, .rst, .avs_address, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_waitrequest, .coreReq, .coreRsp,
  .descRd, .descValid, .descData);
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the segment translation unit.
`default_nettype none
module tb
  import sat_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  sat_core_req_t coreReq = '0;
  sat_core_rsp_t coreRsp;
  sat_desc_rd_t descRd;
  logic descValid;
  logic [63:0] descData;
  logic [1:0] lag = 2'h0;
  logic [31:0] rng = 32'h92f40ab6;
  logic [31:0] rd;
  logic [31:0] ctrl = 32'h0;
  int failCount = 0;
  int nCompared = 0;
  int cycles = 0;
  always #20 clk = ~clk;
  sat_addr_xlate u_dut (.clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .coreReq, .coreRsp, .descRd, .descValid, .descData);
  sat_desc_mem u_mem (.clk, .rst, .descRd, .lag, .descValid, .descData);
  // ==========
  // Helpers.
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic logic [63:0] mkDesc(logic [31:0] b, logic [19:0] l,
    logic g, logic [7:0] ac);
    return {b[31:24], g, 3'h4, l[19:16], ac, b[23:0], l[15:0]};
  endfunction
  task automatic chk(string what, logic [35:0] seen, logic [35:0] exp);
    nCompared++;
    if (seen !== exp) begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic printVerdict();
    $display("compared %0d mismatched %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failCount++;
      printVerdict();
    end
  end
  task automatic bus(logic wr, logic [2:0] a, logic [31:0] d);
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic core(logic ld, logic [2:0] sg, logic [15:0] sl,
    logic [31:0] off, logic wr, logic fe);
    @(posedge clk);
    coreReq <= '{1'b1, ld, sg, sl, off, wr, fe};
    do @(posedge clk); while (coreRsp.done !== 1'b1);
    coreReq.valid <= 1'b0;
  endtask
  task automatic expFlt(logic flt, sat_fault_t ft);
    chk("fault", coreRsp.fault, flt);
    chk("faultType", coreRsp.faultType, ft);
  endtask
  task automatic expAddr(logic [31:0] lin);
    expFlt(1'b0, SAT_FLT_NONE);
    if (ctrl[0]) chk("lin", coreRsp.linAddr, lin);
    else chk("phys", coreRsp.physAddr, {4'h0, lin});
    chk("wide", coreRsp.physWide, ctrl[5]);
  endtask
  // ==========
  // Main sequence.
  initial begin
    logic [31:0] r;
    logic [31:0] b;
    logic [31:0] off;
    logic [31:0] lim;
    logic [15:0] sel;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    core(1'b0, 3'h3, 16'h0, 32'h10, 1'b0, 1'b0);
    expAddr(32'h10);
    core(1'b0, 3'h1, 16'h0, 32'hfff0, 1'b0, 1'b1);
    expAddr(32'hfffffff0);
    bus(1'b1, 3'h2, 32'hffffffff);
    bus(1'b0, 3'h2, 32'h0);
    chk("ctrl", rd, 32'h21);
    bus(1'b0, 3'h6, 32'h0);
    chk("unmapped", rd, 32'h0);
    bus(1'b1, 3'h0, 32'h0);
    bus(1'b1, 3'h1, 32'h400);
    for (int s = 1; s < 4; s++) begin
      r = xs();
      core(1'b1, s[2:0], {14'h0, r[1:0]}, 32'h0, 1'b0, 1'b0);
      expFlt(s < 3, s < 3 ? SAT_FLT_GP : SAT_FLT_NONE);
    end
    core(1'b0, 3'h3, 16'h0, 32'h4, 1'b0, 1'b0);
    expFlt(1'b1, SAT_FLT_GP);
    for (int n = 0; n < 40; n++) begin
      r = xs();
      lag <= r[25:24];
      ctrl = {26'h0, r[27], 4'h0, r[26]};
      bus(1'b1, 3'h2, ctrl);
      sel = {6'h0, r[29:23], r[22], r[31:30]};
      if (sel[15:2] == 14'h0) sel[3] = 1'b1;
      b = xs();
      u_mem.mem[{sel[2], sel[9:3]}] = mkDesc(b, r[19:0], r[20],
        r[21] ? 8'h90 : 8'h92);
      core(1'b1, 3'h4, sel, 32'h0, 1'b0, 1'b0);
      expFlt(1'b0, SAT_FLT_NONE);
      chk("rpl", coreRsp.requester_privilege, sel[1:0]);
      lim = r[20] ? {r[19:0], 12'hfff} : {12'h0, r[19:0]};
      case (r[1:0])
        2'h0: off = lim;
        2'h1: off = lim + 32'h1;
        default: off = xs() & lim;
      endcase
      core(1'b0, 3'h4, 16'h0, off, r[2], 1'b0);
      if (off > lim || (r[2] && r[21])) expFlt(1'b1, SAT_FLT_GP);
      else expAddr(b + off);
    end
    u_mem.mem[5] = mkDesc(32'h0, 20'hfffff, 1'b1, 8'h9a);
    u_mem.mem[6] = mkDesc(32'h0, 20'hfffff, 1'b1, 8'h12);
    u_mem.mem[7] = mkDesc(32'h0, 20'hfffff, 1'b1, 8'h82);
    core(1'b1, 3'h1, 16'h28, 32'h0, 1'b0, 1'b0);
    expFlt(1'b0, SAT_FLT_NONE);
    core(1'b0, 3'h1, 16'h0, 32'hffffffff, 1'b0, 1'b1);
    expAddr(32'hffffffff);
    core(1'b0, 3'h1, 16'h0, 32'h8, 1'b1, 1'b0);
    expFlt(1'b1, SAT_FLT_GP);
    core(1'b1, 3'h4, 16'h30, 32'h0, 1'b0, 1'b0);
    expFlt(1'b1, SAT_FLT_NP);
    core(1'b1, 3'h4, 16'h38, 32'h0, 1'b0, 1'b0);
    expFlt(1'b1, SAT_FLT_GP);
    bus(1'b0, 3'h3, 32'h0);
    chk("stat", rd & 32'h7, 32'h2);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    ctrl = 32'h0;
    core(1'b0, 3'h1, 16'h0, 32'hfff0, 1'b0, 1'b1);
    expAddr(32'hfffffff0);
    core(1'b0, 3'h3, 16'h0, 32'h20, 1'b0, 1'b0);
    expAddr(32'h20);
    printVerdict();
  end
endmodule
`default_nettype wire
